// File: shared/break_matcher_map.vh
`ifndef BREAK_MATCHER_MAP_VH
`define BREAK_MATCHER_MAP_VH
// ----------------------------------------------------------------
// Cycle condition field layout (chan_x_bus_cycle_cond)
// ----------------------------------------------------------------
`define COND_SZ_LO      0
`define COND_SZ_HI      1
`define COND_DIR_LO     2
`define COND_DIR_HI     3
`define COND_TYPE_LO    4
`define COND_TYPE_HI    5
`define COND_MST_LO     6
`define COND_MST_HI     7
`define COND_SPACE_LO   8
`define COND_SPACE_HI   9
`define COND_W          10
// Two-bit field codes
`define F_NONE          2'h0
`define F_FETCH         2'h1
`define F_DATA          2'h2
`define DIR_READ        2'h1
`define DIR_WRITE       2'h2
`define MST_CPU         2'h1
`define MST_DMA         2'h2
`define SZ_ANY          2'h0
`define SZ_BYTE         2'h1
`define SZ_WORD         2'h2
`define SZ_LONG         2'h3
`define SPACE_NORMAL    2'h0
`define SPACE_X         2'h1
`define SPACE_Y         2'h2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_COND        10'h000
`define RST_WORD        32'h00000000
`define RST_ID          8'h00
`define RST_COUNT       12'h000
`endif

// File: hw/cycle_channel.v
`timescale 1ns/1ps
`include "break_matcher_map.vh"
module cycle_channel #(
   parameter AW = 32,
   parameter DW = 32
) (
   input  wire [`COND_W-1:0] i_cond,
   input  wire [AW-1:0]      i_addr_ref,
   input  wire [AW-1:0]      i_addr_mask,
   input  wire [DW-1:0]      i_data_ref,
   input  wire [DW-1:0]      i_data_mask,
   input  wire               i_data_en,
   input  wire               i_id_en,
   input  wire [7:0]         i_id_ref,
   input  wire               i_valid,
   input  wire               i_is_dma,
   input  wire               i_is_fetch,
   input  wire               i_is_write,
   input  wire [1:0]         i_size,
   input  wire [1:0]         i_space,
   input  wire [AW-1:0]      i_addr,
   input  wire [DW-1:0]      i_data,
   input  wire [7:0]         i_id,
   output wire               o_match
);
   wire [1:0] sz  = i_cond[`COND_SZ_HI:`COND_SZ_LO];
   wire [1:0] dir = i_cond[`COND_DIR_HI:`COND_DIR_LO];
   wire [1:0] typ = i_cond[`COND_TYPE_HI:`COND_TYPE_LO];
   wire [1:0] mst = i_cond[`COND_MST_HI:`COND_MST_LO];
   wire [1:0] spc = i_cond[`COND_SPACE_HI:`COND_SPACE_LO];
   // ----------------------------------------------------------------
   // Field comparisons
   // ----------------------------------------------------------------
   wire mst_ok = (mst == `MST_CPU) ? !i_is_dma :
                 (mst == `MST_DMA) ?  i_is_dma : 1'b0;
   wire typ_ok = (typ == `F_FETCH) ?  i_is_fetch :
                 (typ == `F_DATA)  ? !i_is_fetch : 1'b1;
   wire dir_ok = (dir == `DIR_READ)  ? !i_is_write :
                 (dir == `DIR_WRITE) ?  i_is_write : 1'b1;
   wire sz_ok  = (sz == `SZ_ANY) || (sz == i_size);
   wire spc_ok = i_is_fetch || (spc == i_space);
   wire impossible = ((typ == `F_FETCH) && (dir == `DIR_WRITE)) ||
                     ((typ == `F_FETCH) && (mst == `MST_DMA));
   // Size excluded: longword reads and writes compare aligned address
   wire [AW-1:0] amask = i_addr_mask |
                  ((sz == `SZ_ANY && i_size == `SZ_LONG) ?
                   {{(AW-2){1'b0}}, 2'h3} : {AW{1'b0}});
   wire addr_ok = ((i_addr ^ i_addr_ref) & ~amask) == {AW{1'b0}};
   wire data_ok = !i_data_en ||
                  (((i_data ^ i_data_ref) & ~i_data_mask) ==
                   {DW{1'b0}});
   wire id_ok   = !i_id_en || (i_id == i_id_ref);
   assign o_match = i_valid && !impossible && mst_ok && typ_ok &&
                    dir_ok && sz_ok && spc_ok && addr_ok && data_ok &&
                    id_ok;
endmodule // cycle_channel

// File: hw/exec_counter.v
`timescale 1ns/1ps
`include "break_matcher_map.vh"
module exec_counter #(
   parameter CW = 12
) (
   input  wire          i_clk,
   input  wire          i_rst_n,
   input  wire          i_load,
   input  wire [CW-1:0] i_load_val,
   input  wire          i_hit,
   output wire          o_last,
   output reg  [CW-1:0] o_count
);
   // ----------------------------------------------------------------
   // Down counter; break fires on the hit seen at a count of one
   // ----------------------------------------------------------------
   assign o_last = (o_count == {{(CW-1){1'b0}}, 1'b1});
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_count <= `RST_COUNT;
      end else if (i_load) begin
         o_count <= i_load_val;
      end else if (i_hit && o_count != {CW{1'b0}}) begin
         o_count <= o_count - {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule // exec_counter

// File: hw/bus_cycle_break_matcher.v
`timescale 1ns/1ps
`include "break_matcher_map.vh"
module bus_cycle_break_matcher #(
   parameter AW = 32,
   parameter DW = 32,
   parameter CW = 12
) (
   input  wire               i_clk,
   input  wire               i_rst_n,
   // Configuration write port (memory-access stage)
   input  wire               i_cfg_wr,
   input  wire               i_cfg_from_cpu,
   input  wire [3:0]         i_cfg_sel,
   input  wire [DW-1:0]      i_cfg_wdata,
   // Observed bus cycle
   input  wire               i_cyc_valid,
   input  wire               i_cyc_dma,
   input  wire               i_cyc_fetch,
   input  wire               i_cyc_write,
   input  wire [1:0]         i_cyc_size,
   input  wire [1:0]         i_cyc_space,
   input  wire [AW-1:0]      i_cyc_addr,
   input  wire [DW-1:0]      i_cyc_data,
   input  wire [7:0]         i_cyc_id,
   input  wire               i_in_short_loop,
   // Exception sources for the same instruction
   input  wire               i_fetch_exc,
   input  wire               i_operand_exc,
   // Flag clear from software
   input  wire               i_flag_clr,
   // Results
   output reg                o_break_req,
   output reg                o_break_after,
   output reg                o_fetch_exc_take,
   output reg                o_operand_exc_take,
   output reg                o_flag_a,
   output reg                o_flag_b,
   output reg  [CW-1:0]      o_exec_count
);
   // ----------------------------------------------------------------
   // Register select codes
   // ----------------------------------------------------------------
   localparam [3:0] SEL_CTRL  = 4'h0;
   localparam [3:0] SEL_CONDA = 4'h1;
   localparam [3:0] SEL_ADRA  = 4'h2;
   localparam [3:0] SEL_AMKA  = 4'h3;
   localparam [3:0] SEL_IDA   = 4'h4;
   localparam [3:0] SEL_CONDB = 4'h5;
   localparam [3:0] SEL_ADRB  = 4'h6;
   localparam [3:0] SEL_AMKB  = 4'h7;
   localparam [3:0] SEL_DATB  = 4'h8;
   localparam [3:0] SEL_DMKB  = 4'h9;
   localparam [3:0] SEL_IDB   = 4'hA;
   localparam [3:0] SEL_COUNT = 4'hB;
   // Control bits: 0 seq, 1 count en, 2 data en B, 3 id en,
   // 4 A after-exec, 5 B after-exec
   reg [5:0]         ctrl_q;
   reg [`COND_W-1:0] cond_a_q;
   reg [`COND_W-1:0] cond_b_q;
   reg [AW-1:0]      adr_a_q;
   reg [AW-1:0]      amk_a_q;
   reg [AW-1:0]      adr_b_q;
   reg [AW-1:0]      amk_b_q;
   reg [DW-1:0]      dat_b_q;
   reg [DW-1:0]      dmk_b_q;
   reg [7:0]         id_a_q;
   reg [7:0]         id_b_q;
   reg               armed_q;
   wire              seq_mode  = ctrl_q[0];
   wire              count_en  = ctrl_q[1];
   wire              data_en   = ctrl_q[2];
   wire              id_en     = ctrl_q[3];
   wire              after_a   = ctrl_q[4];
   wire              after_b   = ctrl_q[5];
   wire              cpu_wr    = i_cfg_wr && i_cfg_from_cpu;
   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Writes land in the memory-access stage; the fetch already on the bus
   // sees the old setting because comparators read the stored value.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q   <= 6'h00;
         cond_a_q <= `RST_COND;
         cond_b_q <= `RST_COND;
         adr_a_q  <= `RST_WORD;
         amk_a_q  <= `RST_WORD;
         adr_b_q  <= `RST_WORD;
         amk_b_q  <= `RST_WORD;
         dat_b_q  <= `RST_WORD;
         dmk_b_q  <= `RST_WORD;
         id_a_q   <= `RST_ID;
         id_b_q   <= `RST_ID;
      end else if (cpu_wr) begin
         case (i_cfg_sel)
            SEL_CTRL:  ctrl_q   <= i_cfg_wdata[5:0];
            SEL_CONDA: cond_a_q <= i_cfg_wdata[`COND_W-1:0];
            SEL_ADRA:  adr_a_q  <= i_cfg_wdata[AW-1:0];
            SEL_AMKA:  amk_a_q  <= i_cfg_wdata[AW-1:0];
            SEL_IDA:   id_a_q   <= i_cfg_wdata[7:0];
            SEL_CONDB: cond_b_q <= i_cfg_wdata[`COND_W-1:0];
            SEL_ADRB:  adr_b_q  <= i_cfg_wdata[AW-1:0];
            SEL_AMKB:  amk_b_q  <= i_cfg_wdata[AW-1:0];
            SEL_DATB:  dat_b_q  <= i_cfg_wdata;
            SEL_DMKB:  dmk_b_q  <= i_cfg_wdata;
            SEL_IDB:   id_b_q   <= i_cfg_wdata[7:0];
            default:   ctrl_q   <= ctrl_q;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Channel comparators
   // ----------------------------------------------------------------
   wire hit_a;
   wire hit_b;
   wire cyc_ok = i_cyc_valid && !i_in_short_loop;
   cycle_channel #(.AW(AW), .DW(DW)) u_chan_a (
      .i_cond      (cond_a_q),
      .i_addr_ref  (adr_a_q),
      .i_addr_mask (amk_a_q),
      .i_data_ref  ({DW{1'b0}}),
      .i_data_mask ({DW{1'b1}}),
      .i_data_en   (1'b0),
      .i_id_en     (id_en),
      .i_id_ref    (id_a_q),
      .i_valid     (cyc_ok),
      .i_is_dma    (i_cyc_dma),
      .i_is_fetch  (i_cyc_fetch),
      .i_is_write  (i_cyc_write),
      .i_size      (i_cyc_size),
      .i_space     (i_cyc_space),
      .i_addr      (i_cyc_addr),
      .i_data      (i_cyc_data),
      .i_id        (i_cyc_id),
      .o_match     (hit_a)
   );
   cycle_channel #(.AW(AW), .DW(DW)) u_chan_b (
      .i_cond      (cond_b_q),
      .i_addr_ref  (adr_b_q),
      .i_addr_mask (amk_b_q),
      .i_data_ref  (dat_b_q),
      .i_data_mask (dmk_b_q),
      .i_data_en   (data_en),
      .i_id_en     (id_en),
      .i_id_ref    (id_b_q),
      .i_valid     (cyc_ok),
      .i_is_dma    (i_cyc_dma),
      .i_is_fetch  (i_cyc_fetch),
      .i_is_write  (i_cyc_write),
      .i_size      (i_cyc_size),
      .i_space     (i_cyc_space),
      .i_addr      (i_cyc_addr),
      .i_data      (i_cyc_data),
      .i_id        (i_cyc_id),
      .o_match     (hit_b)
   );
   // ----------------------------------------------------------------
   // Execution count on channel B
   // ----------------------------------------------------------------
   wire          cnt_last;
   wire [CW-1:0] cnt_val;
   wire          cnt_load = cpu_wr && (i_cfg_sel == SEL_COUNT);
   exec_counter #(.CW(CW)) u_count (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_load     (cnt_load),
      .i_load_val (i_cfg_wdata[CW-1:0]),
      .i_hit      (hit_b && count_en),
      .o_last     (cnt_last),
      .o_count    (cnt_val)
   );
   wire b_fire = hit_b && (!count_en || cnt_last);
   // ----------------------------------------------------------------
   // Sequence and break decision
   // ----------------------------------------------------------------
   wire a_fetch_before = !after_a &&
        (cond_a_q[`COND_TYPE_HI:`COND_TYPE_LO] == `F_FETCH);
   // Armed only by an A match in an earlier bus cycle
   wire seq_hit = armed_q && b_fire;
   wire same_hit = hit_a && b_fire && a_fetch_before;
   wire brk_a = seq_mode ? 1'b0 : hit_a;
   wire brk_b = seq_mode ? (seq_hit || same_hit) : b_fire;
   wire brk   = brk_a || brk_b;
   wire brk_is_after = brk_a ? after_a : after_b;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_q <= 1'b0;
      end else if (!seq_mode || brk_b) begin
         armed_q <= 1'b0;
      end else if (hit_a) begin
         armed_q <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Exception priority and outputs
   // ----------------------------------------------------------------
   reg brk_d;
   reg fexc_d;
   reg oexc_d;
   always @* begin
      brk_d  = brk;
      fexc_d = i_fetch_exc;
      oexc_d = i_operand_exc;
      if (i_fetch_exc) begin
         brk_d = 1'b0;
      end else if (brk && !brk_is_after) begin
         oexc_d = 1'b0;
      end else if (brk && i_operand_exc) begin
         brk_d = 1'b0;
      end
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_break_req        <= 1'b0;
         o_break_after      <= 1'b0;
         o_fetch_exc_take   <= 1'b0;
         o_operand_exc_take <= 1'b0;
         o_flag_a           <= 1'b0;
         o_flag_b           <= 1'b0;
         o_exec_count       <= `RST_COUNT;
      end else begin
         o_break_req        <= brk_d;
         o_break_after      <= brk_d && brk_is_after;
         o_fetch_exc_take   <= fexc_d;
         o_operand_exc_take <= oexc_d;
         o_exec_count       <= cnt_val;
         // Set wins over clear
         o_flag_a <= (hit_a && (!seq_mode || brk_b)) ||
                     (o_flag_a && !i_flag_clr);
         o_flag_b <= brk_b || (o_flag_b && !i_flag_clr);
      end
   end
endmodule // bus_cycle_break_matcher

// File: verification/bus_cycle_break_matcher_props.sv
`timescale 1ns/1ps
module bus_cycle_break_matcher_props #(parameter AW=32, DW=32, CW=12) (
   input wire          i_clk, i_rst_n, i_cfg_wr, i_cfg_from_cpu,
   input wire [3:0]    i_cfg_sel,
   input wire [DW-1:0] i_cfg_wdata, i_cyc_data,
   input wire          i_cyc_valid, i_cyc_dma, i_cyc_fetch, i_cyc_write,
   input wire [1:0]    i_cyc_size, i_cyc_space,
   input wire [AW-1:0] i_cyc_addr,
   input wire [7:0]    i_cyc_id,
   input wire          i_in_short_loop, i_fetch_exc, i_operand_exc,
   input wire          i_flag_clr, o_break_req, o_break_after,
   input wire          o_fetch_exc_take, o_operand_exc_take,
   input wire          o_flag_a, o_flag_b,
   input wire [CW-1:0] o_exec_count
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire quiet = (!i_cyc_valid || i_in_short_loop) && !i_cfg_wr;
   a_idle_no_brk: assert property (!i_cyc_valid |=> !o_break_req)
      else $error("break without bus cycle");
   a_loop_no_brk: assert property (
      i_cyc_valid && i_in_short_loop |=> !o_break_req)
      else $error("break inside short loop");
   a_count_hold: assert property (
      quiet ##1 quiet |=> $stable(o_exec_count))
      else $error("count moved without a counted cycle");
   a_fetch_exc_first: assert property (
      i_cyc_valid && i_fetch_exc |=> o_fetch_exc_take && !o_break_req)
      else $error("break taken over fetch exception");
   a_before_first: assert property (
      o_break_req && !o_break_after |-> !o_operand_exc_take)
      else $error("operand exception over early break");
   a_operand_first: assert property (
      o_operand_exc_take |-> !(o_break_req && o_break_after))
      else $error("late break over operand exception");
   a_flag_sticky: assert property (
      o_flag_a && !i_flag_clr |=> o_flag_a)
      else $error("match flag lost without clear");
   a_break_flags: assert property (
      o_break_req |-> o_flag_a || o_flag_b)
      else $error("break without match flag");
   c_after: cover property (o_break_req && o_break_after);
   c_both: cover property (o_flag_a && o_flag_b);
   c_fexc: cover property (o_fetch_exc_take);
   c_oexc: cover property (o_operand_exc_take);
endmodule // bus_cycle_break_matcher_props
bind bus_cycle_break_matcher bus_cycle_break_matcher_props
   #(.AW(AW), .DW(DW), .CW(CW)) props_i (.*);

// File: verification/bus_cycle_model.sv
`timescale 1ns/1ps
module bus_cycle_model (
   input  wire        i_clk,
   output reg  [82:0] o_cyc
);
   // ----------------------------------------------------------------
   // Processor and DMA bus cycles, one per call
   // ----------------------------------------------------------------
   initial o_cyc = 83'h0;
   // Only fetch and data cycles, never a branch after a trace read
   task cyc(input [6:0] c, input [31:0] a, d, input [7:0] id,
            input [2:0] s);
      @(posedge i_clk) #1;
      // DMA never fetches and fetches never write
      o_cyc = {1'b1, c[6], c[5] & ~c[6], c[4] & ~c[5], c[3:0],
               a, d, id, s};
      @(posedge i_clk) #1;
      // Released address, data and id lines show the inverse of the last value
      o_cyc = {1'b0, 6'h00, ~a, ~d, ~id, 3'h0};
   endtask
endmodule // bus_cycle_model

// File: verification/bus_cycle_break_matcher_test.sv
`timescale 1ns/1ps
module bus_cycle_break_matcher_test;
   // ----------------------------------------------------------------
   // Bench
   // ----------------------------------------------------------------
   localparam DL = 1;
   localparam [6:0] FW = 7'h28, FL = 7'h2C, RL = 7'h0C, RW = 7'h08,
      RB = 7'h04, WW = 7'h18, WY = 7'h1A, DB = 7'h54, CB = 7'h14, DR = 7'h4C;
   reg         i_clk, i_rst_n, i_cfg_wr, i_cfg_from_cpu, i_flag_clr;
   reg  [3:0]  i_cfg_sel;
   reg  [31:0] i_cfg_wdata;
   wire        i_cyc_valid, i_cyc_dma, i_cyc_fetch, i_cyc_write;
   wire        i_in_short_loop, i_fetch_exc, i_operand_exc;
   wire        o_break_req, o_break_after, o_fetch_exc_take;
   wire        o_operand_exc_take, o_flag_a, o_flag_b;
   wire [1:0]  i_cyc_size, i_cyc_space;
   wire [31:0] i_cyc_addr, i_cyc_data;
   wire [7:0]  i_cyc_id;
   wire [11:0] o_exec_count;
   wire [82:0] cyc;
   integer     fails = 0, checked = 0, seed = 32'hDE19, k;
   reg  [3:0]  notes [$];
   reg  [3:0]  e;
   assign {i_cyc_valid, i_cyc_dma, i_cyc_fetch, i_cyc_write, i_cyc_size,
      i_cyc_space, i_cyc_addr, i_cyc_data, i_cyc_id, i_in_short_loop,
      i_fetch_exc, i_operand_exc} = cyc;
   bus_cycle_break_matcher bus_cycle_break_matcher_i (.*);
   bus_cycle_model bus_cycle_model_i (.i_clk(i_clk), .o_cyc(cyc));
   initial begin
      i_clk = 0;
      forever #50 i_clk = ~i_clk;
   end
   task bad(input string m);
      fails = fails + 1;
      $display("ERROR %0t %s", $time, m);
   endtask
   task cmp_brk(input [3:0] x);
      checked = checked + 1;
      if (o_break_req !== x[3] || o_break_after !== (x[3] & x[2]))
         bad("break request");
   endtask
   task cmp_exc(input [3:0] x);
      checked = checked + 1;
      if ({o_fetch_exc_take, o_operand_exc_take} !== x[1:0]) bad("exception");
   endtask
   task cmp_flg(input [1:0] x);
      checked = checked + 1;
      if ({o_flag_a, o_flag_b} !== x) bad("match flags");
   endtask
   task cmp_cnt(input [11:0] x);
      checked = checked + 1;
      if (o_exec_count !== x) bad("execution count");
   endtask
   task stop_test;
      $display("Counts: checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cfg(input [3:0] s, input [31:0] v, input cpu);
      @(posedge i_clk) #DL;
      {i_cfg_wr, i_cfg_from_cpu, i_cfg_sel, i_cfg_wdata} = {1'b1, cpu, s, v};
      @(posedge i_clk) #DL;
      i_cfg_wr = 0;
   endtask
   task setup(input [31:0] c0, ca, aa, ma, cb, ab, mb, db, dm);
      cfg(0, c0, 1); cfg(1, ca, 1); cfg(2, aa, 1); cfg(3, ma, 1);
      cfg(4, 32'h80, 1); cfg(5, cb, 1); cfg(6, ab, 1); cfg(7, mb, 1);
      cfg(8, db, 1); cfg(9, dm, 1); cfg(4'hA, 32'h70, 1);
      i_flag_clr = 1;
      @(posedge i_clk) #DL;
      i_flag_clr = 0;
   endtask
   task go(input [3:0] x, input [6:0] c, input [31:0] a, d, input [7:0] id,
           input [2:0] s);
      notes.push_back(x);
      bus_cycle_model_i.cyc(c, a, d, id, s);
   endtask
   always @(posedge i_clk) if (i_cyc_valid === 1'b1) begin
      #50;
      e = notes.pop_front();
      cmp_brk(e);
      cmp_exc(e);
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      bad("timeout");
      stop_test;
   end
   initial begin
      {i_rst_n, i_cfg_wr, i_cfg_from_cpu, i_flag_clr} = 4'h0;
      {i_cfg_sel, i_cfg_wdata} = 36'h0;
      repeat (20) @(posedge i_clk);
      #DL i_rst_n = 1;
      setup(32'h18, 32'h54, 32'h8404, 32'hFFF, 0, 0, 0, 0, 0);
      go(4'hC, FW, 32'h8000 | ($random(seed) & 32'hFFE), 0, 8'h80, 0);
      go(0, FW, 32'h9000, 0, 8'h80, 0);
      go(0, FW, 32'h8400, 0, 8'h70, 0);
      go(0, RL, 32'h8400, 0, 8'h80, 0);
      cmp_flg(2'h2);
      $display("Test mask done");
      setup(0, 32'h64, 32'h123456, 0, 0, 0, 0, 0, 0);
      go(8, RL, 32'h123454, 0, 0, 0);
      go(8, RW, 32'h123456, 0, 0, 0);
      go(8, RB, 32'h123456, 0, 0, 0);
      go(0, RB, 32'h123457, 0, 0, 0);
      go(0, WW, 32'h123456, 0, 0, 0);
      go(0, DR, 32'h123456, 0, 0, 0);
      $display("Test size done");
      setup(32'h24, 0, 0, 0, 32'hA9, 32'h55555, 0, 32'h78, 32'hF);
      go(4'hC, DB, 32'h55555, 32'h70 | ($random(seed) & 32'hF), 0, 0);
      go(0, DB, 32'h55555, 32'h68, 0, 0);
      go(0, CB, 32'h55555, 32'h78, 0, 0);
      setup(4, 0, 0, 0, 32'h26A, 32'hF000, 32'hFFFF0000, 32'h4567, 0);
      go(8, WY, 32'h1F000, 32'h4567, 0, 0);
      go(0, WW, 32'h1F000, 32'h4567, 0, 0);
      cmp_flg(2'h1);
      $display("Test data done");
      setup(1, 32'h5A, 32'h37226, 0, 32'h56, 32'h3722E, 0, 0, 0);
      go(0, FW, 32'h37226, 0, 0, 0);
      go(0, FW, 32'h3722E, 0, 0, 0);
      setup(0, 32'h94, 32'h314156, 0, 0, 0, 0, 0, 0);
      go(0, DR, 32'h314156, 0, 0, 0);
      $display("Test never done");
      setup(1, 32'h64, 32'h100, 0, 32'h54, 32'h200, 0, 0, 0);
      go(0, FW, 32'h200, 0, 0, 0);
      go(0, RL, 32'h100, 0, 0, 0);
      go(8, FW, 32'h200, 0, 0, 0);
      cmp_flg(2'h1);
      setup(1, 32'h64, 32'h100, 0, 32'h64, 32'h100, 0, 0, 0);
      go(0, RL, 32'h100, 0, 0, 0);
      @(posedge i_clk);
      #DL i_rst_n = 0;
      repeat (2) @(posedge i_clk);
      #DL i_rst_n = 1;
      setup(1, 32'h54, 32'h300, 0, 32'h54, 32'h300, 0, 0, 0);
      go(8, FW, 32'h300, 0, 0, 0);
      cmp_flg(2'h3);
      $display("Test sequence done");
      setup(2, 0, 0, 0, 32'h57, 32'h1000, 0, 0, 0);
      cfg(4'hB, 32'h5, 1);
      for (k = 0; k < 4; k = k + 1) go(0, FL, 32'h1000, 0, 0, 0);
      go(0, FL, 32'h1000, 0, 0, 3'h4);
      cfg(4'hB, 32'h3, 0);
      repeat (2) @(posedge i_clk);
      #DL cmp_cnt(12'h001);
      go(8, FL, 32'h1000, 0, 0, 0);
      $display("Test count done");
      setup(0, 32'h54, 32'h400, 0, 0, 0, 0, 0, 0);
      go(4'h2, FW, 32'h400, 0, 0, 3'h2);
      go(4'h8, FW, 32'h400, 0, 0, 3'h1);
      cfg(0, 32'h10, 1);
      go(4'h1, FW, 32'h400, 0, 0, 3'h1);
      $display("Test priority done");
      setup(0, 0, 32'h500, 0, 0, 0, 0, 0, 0);
      cfg(1, 32'h54, 0);
      go(0, FW, 32'h500, 0, 0, 0);
      fork
         cfg(1, 32'h54, 1);
         go(0, FW, 32'h500, 0, 0, 0);
      join
      go(8, FW, 32'h500, 0, 0, 0);
      $display("Test config done");
      repeat (3) @(posedge i_clk);
      stop_test;
   end
endmodule // bus_cycle_break_matcher_test
